// File: verilog/alarm_clamp_pkg.sv
package alarm_clamp_pkg;
  localparam logic [7:0]  ADDR_CLAMP_ROUTING = 8'h1A;
  localparam logic [7:0]  ADDR_OUTPUT_CONFIG = 8'h1B;
  localparam logic [7:0]  ADDR_ALARM_STATUS  = 8'h1D;
  localparam logic [7:0]  ADDR_AMP_COMMAND   = 8'h1E;
  localparam logic [7:0]  ADDR_CLAMP_WAKE    = 8'h1F;
  localparam logic [15:0] RST_CLAMP_ROUTING  = 16'h0000;
  localparam logic [15:0] RST_OUTPUT_CONFIG  = 16'h0000;
  localparam logic [15:0] CLAMP_ROUTING_MASK = 16'h007F;
  localparam int          POS_AMP_OFF        = 6;
  localparam int          POS_HOLD_DIS       = 15;
  localparam int          POS_POLARITY       = 14;
  localparam int          POS_SRC_SEL        = 13;
  localparam int          NUM_EVENTS         = 13;
  localparam int          NUM_CLAMPS         = 6;
endpackage

// File: verilog/alarm_output_clamp_control.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
// Notes on behaviour
// - amp-off bit lets alarm force amp off
// - amp stays off until commanded back on
// - enabled clamp bits clamp converters on alarm
// - clamp holds until explicit wake write
// - clamp bit zero means unaffected
// - latched mode holds flags once set
// - latched flag clears after subside and read
// - unlatched flags follow the condition
// - polarity bit sets pin active level
// - source-select routes thresholds to inputs or sense
// - thirteen enable bits pick alarm sources
// - disabled events never assert the pin
module alarm_output_clamp_control
(
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic [12:0] I_EVENT,
  output logic      [15:0] O_RDATA,
  output logic             O_ALARM_PIN,
  output logic             O_AMP_ENABLE,
  output logic      [5:0]  O_CLAMP,
  output logic             O_THRESH_SENSE_SEL
);

  // events come from outside this clock domain, so two flops first
  logic [12:0] evt_meta_ff;
  logic [12:0] evt_sync_ff;
  logic [15:0] routing_ff;
  logic [15:0] config_ff;
  logic [12:0] flag_ff;
  logic        read_seen_ff;
  logic [12:0] read_mark_ff;
  logic        amp_on_ff;
  logic [5:0]  clamp_ff;
  logic [15:0] rdata_ff;
  logic        alarm_pin_ff;
  logic [15:0] nxt_routing;
  logic [15:0] nxt_config;
  logic [12:0] nxt_flag;
  logic [12:0] nxt_read_mark;
  logic        nxt_amp_on;
  logic [5:0]  nxt_clamp;
  logic [15:0] nxt_rdata;
  logic        nxt_alarm_pin;
  logic        alarm_active;
  logic        wr_routing;
  logic        wr_config;
  logic        rd_status;
  logic        wr_amp;
  logic        wr_wake;

  always_comb
  begin
    wr_routing = 1'b0;
    wr_config  = 1'b0;
    wr_amp     = 1'b0;
    wr_wake    = 1'b0;
    rd_status  = 1'b0;
    if (I_WR && I_ADDR == alarm_clamp_pkg::ADDR_CLAMP_ROUTING)
    begin
      wr_routing = 1'b1;
    end
    else if (I_WR && I_ADDR == alarm_clamp_pkg::ADDR_OUTPUT_CONFIG)
    begin
      wr_config = 1'b1;
    end
    else if (I_WR && I_ADDR == alarm_clamp_pkg::ADDR_AMP_COMMAND)
    begin
      wr_amp = 1'b1;
    end
    else if (I_WR && I_ADDR == alarm_clamp_pkg::ADDR_CLAMP_WAKE)
    begin
      wr_wake = 1'b1;
    end
    else if (I_RD && I_ADDR == alarm_clamp_pkg::ADDR_ALARM_STATUS)
    begin
      rd_status = 1'b1;
    end
  end

  // alarm output active level, from registered flags and enables
  assign alarm_active = |(flag_ff & config_ff[12:0]);

  always_comb
  begin
    nxt_routing = routing_ff;
    nxt_config  = config_ff;
    if (wr_routing)
    begin
      nxt_routing = I_WDATA & alarm_clamp_pkg::CLAMP_ROUTING_MASK;
    end
    if (wr_config)
    begin
      nxt_config = I_WDATA;
    end
  end

  // flags: a read marks which flags were set; a marked flag clears once
  // its condition is gone, so a new event in the same cycle always wins
  always_comb
  begin
    nxt_flag      = flag_ff;
    nxt_read_mark = read_mark_ff;
    if (config_ff[alarm_clamp_pkg::POS_HOLD_DIS])
    begin
      nxt_flag      = evt_sync_ff;
      nxt_read_mark = '0;
    end
    else
    begin
      if (rd_status)
      begin
        nxt_read_mark = read_mark_ff | flag_ff;
      end
      nxt_flag = (flag_ff & ~(nxt_read_mark & ~evt_sync_ff)) | evt_sync_ff;
      nxt_read_mark = nxt_read_mark & nxt_flag;
    end
  end

  always_comb
  begin
    nxt_amp_on = amp_on_ff;
    nxt_clamp  = clamp_ff;
    if (wr_amp && I_WDATA[0])
    begin
      nxt_amp_on = 1'b1;
    end
    else if (wr_amp)
    begin
      nxt_amp_on = 1'b0;
    end
    if (wr_wake)
    begin
      nxt_clamp = clamp_ff & ~I_WDATA[5:0];
    end
    if (alarm_active && routing_ff[alarm_clamp_pkg::POS_AMP_OFF])
    begin
      nxt_amp_on = 1'b0;
    end
    // alarm wins over a wake write in the same cycle
    nxt_clamp = nxt_clamp | ({6{alarm_active}} & routing_ff[5:0]);
  end

  always_comb
  begin
    nxt_rdata = 16'h0000;
    if (I_RD && I_ADDR == alarm_clamp_pkg::ADDR_CLAMP_ROUTING)
    begin
      nxt_rdata = routing_ff;
    end
    else if (I_RD && I_ADDR == alarm_clamp_pkg::ADDR_OUTPUT_CONFIG)
    begin
      nxt_rdata = config_ff;
    end
    else if (rd_status)
    begin
      nxt_rdata = {3'h0, flag_ff};
    end
    else if (I_RD && I_ADDR == alarm_clamp_pkg::ADDR_AMP_COMMAND)
    begin
      nxt_rdata = {15'h0000, amp_on_ff};
    end
    else if (I_RD && I_ADDR == alarm_clamp_pkg::ADDR_CLAMP_WAKE)
    begin
      nxt_rdata = {10'h000, clamp_ff};
    end
    nxt_alarm_pin = alarm_active ~^ config_ff[alarm_clamp_pkg::POS_POLARITY];
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      evt_meta_ff  <= '0;
      evt_sync_ff  <= '0;
      routing_ff   <= alarm_clamp_pkg::RST_CLAMP_ROUTING;
      config_ff    <= alarm_clamp_pkg::RST_OUTPUT_CONFIG;
      flag_ff      <= '0;
      read_mark_ff <= '0;
      amp_on_ff    <= 1'b0;
      clamp_ff     <= '0;
      rdata_ff     <= 16'h0000;
      alarm_pin_ff <= 1'b1;
    end
    else
    begin
      evt_meta_ff  <= I_EVENT;
      evt_sync_ff  <= evt_meta_ff;
      routing_ff   <= nxt_routing;
      config_ff    <= nxt_config;
      flag_ff      <= nxt_flag;
      read_mark_ff <= nxt_read_mark;
      amp_on_ff    <= nxt_amp_on;
      clamp_ff     <= nxt_clamp;
      rdata_ff     <= nxt_rdata;
      alarm_pin_ff <= nxt_alarm_pin;
    end
  end

  assign O_RDATA            = rdata_ff;
  assign O_ALARM_PIN        = alarm_pin_ff;
  assign O_AMP_ENABLE       = amp_on_ff;
  assign O_CLAMP            = clamp_ff;
  assign O_THRESH_SENSE_SEL = config_ff[alarm_clamp_pkg::POS_SRC_SEL];

  // read_seen_ff is helper state for the checks below
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      read_seen_ff <= 1'b0;
    end
    else
    begin
      read_seen_ff <= rd_status;
    end
  end

  property p_amp_forced_off;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (alarm_active && routing_ff[alarm_clamp_pkg::POS_AMP_OFF]) |=> !O_AMP_ENABLE;
  endproperty
  a_amp_forced_off: assert property (p_amp_forced_off) else $error("amp not forced off");

  property p_amp_stays_off;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (!O_AMP_ENABLE && !wr_amp) |=> !O_AMP_ENABLE;
  endproperty
  a_amp_stays_off: assert property (p_amp_stays_off) else $error("amp came back on");

  property p_clamp_set;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      alarm_active |=> ((O_CLAMP & $past(routing_ff[5:0])) == $past(routing_ff[5:0]));
  endproperty
  a_clamp_set: assert property (p_clamp_set) else $error("clamp not applied");

  property p_clamp_holds;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      !wr_wake |=> ((O_CLAMP & $past(O_CLAMP)) == $past(O_CLAMP));
  endproperty
  a_clamp_holds: assert property (p_clamp_holds) else $error("clamp released");

  property p_clamp_unrouted;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (!wr_wake && routing_ff[0] == 1'b0) |=> (O_CLAMP[0] == $past(O_CLAMP[0]));
  endproperty
  a_clamp_unrouted: assert property (p_clamp_unrouted) else $error("unrouted clamp moved");

  property p_flag_latched;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (!config_ff[alarm_clamp_pkg::POS_HOLD_DIS] && !wr_config && flag_ff[0] && !read_mark_ff[0]
       && !rd_status) |=> flag_ff[0];
  endproperty
  a_flag_latched: assert property (p_flag_latched) else $error("flag dropped unread");

  property p_flag_follows;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      config_ff[alarm_clamp_pkg::POS_HOLD_DIS] |=> (flag_ff == $past(evt_sync_ff));
  endproperty
  a_flag_follows: assert property (p_flag_follows) else $error("flag not following");

  property p_pin_level;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      1'b1 |=> (O_ALARM_PIN ==
        ($past(alarm_active) ~^ $past(config_ff[alarm_clamp_pkg::POS_POLARITY])));
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("alarm pin wrong level");

  property p_disabled_event;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (config_ff[12:0] == 13'h0000) |-> !alarm_active;
  endproperty
  a_disabled_event: assert property (p_disabled_event) else $error("event not enabled");

  // an event needs three edges to reach its flag: two sync flops, then the flag
  sequence s_event_synced;
    ##1 (evt_meta_ff == $past(I_EVENT)) ##1 (evt_sync_ff == $past(I_EVENT, 2));
  endsequence

  sequence s_event_flagged;
    ((flag_ff & $past(I_EVENT, 3)) == $past(I_EVENT, 3));
  endsequence

  property p_event_path;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      1'b1 |-> s_event_synced ##1 s_event_flagged;
  endproperty
  a_event_path: assert property (p_event_path) else $error("event lost before flag");

  property p_status_readback;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      read_seen_ff |-> (O_RDATA == {3'h0, $past(flag_ff)});
  endproperty
  a_status_readback: assert property (p_status_readback) else $error("bad status");

  property p_amp_on_write;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (wr_amp && I_WDATA[0] && !(alarm_active && routing_ff[alarm_clamp_pkg::POS_AMP_OFF]))
        |=> O_AMP_ENABLE;
  endproperty
  a_amp_on_write: assert property (p_amp_on_write) else $error("amp not turned on");

  property p_clamp_wake;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (wr_wake && !alarm_active) |=> ((O_CLAMP & $past(I_WDATA[5:0])) == 6'h00);
  endproperty
  a_clamp_wake: assert property (p_clamp_wake) else $error("clamp not woken");

  property p_amp_unrouted;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (!routing_ff[alarm_clamp_pkg::POS_AMP_OFF] && !wr_amp) |=> $stable(O_AMP_ENABLE);
  endproperty
  a_amp_unrouted: assert property (p_amp_unrouted) else $error("amp moved unrouted");

  property p_flag_cleared;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (!config_ff[alarm_clamp_pkg::POS_HOLD_DIS] && rd_status)
        |=> ((flag_ff & ~$past(evt_sync_ff)) == 13'h0000);
  endproperty
  a_flag_cleared: assert property (p_flag_cleared) else $error("read flag not cleared");

  property p_pin_follows;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (|(flag_ff & config_ff[12:0]))
        |=> (O_ALARM_PIN == $past(config_ff[alarm_clamp_pkg::POS_POLARITY]));
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("pin not asserted");

  property p_pin_idle;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      ((flag_ff & config_ff[12:0]) == 13'h0000)
        |=> (O_ALARM_PIN != $past(config_ff[alarm_clamp_pkg::POS_POLARITY]));
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("pin active with no flag");

  property p_sense_sel;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      wr_config |=> (O_THRESH_SENSE_SEL == $past(I_WDATA[alarm_clamp_pkg::POS_SRC_SEL]));
  endproperty
  a_sense_sel: assert property (p_sense_sel) else $error("threshold source wrong");

endmodule

// File: dv/alarm_host_model.sv
`timescale 1ns/1ns
module alarm_host_model
(
  input  wire logic I_CLK,
  input  wire logic i_pin,
  input  wire logic i_active_high,
  output logic      o_alarm_seen
);
  // the host only sees the pin, so it needs the polarity to tell alarm from idle
  always_ff @(posedge I_CLK)
    o_alarm_seen <= (i_pin == i_active_high);
endmodule

// File: dv/alarm_output_clamp_control_bench.sv
`timescale 1ns/1ns
`define CMP(e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: exp %h got %h", $time, e, g); end end
module alarm_output_clamp_control_bench;
  logic        I_CLK = 1'b0, I_SYS_RST = 1'b1, I_WR = 1'b0, I_RD = 1'b0;
  logic        pol = 1'b0, look = 1'b0, rd_d = 1'b0, seen;
  logic [7:0]  I_ADDR = 8'h00;
  logic [15:0] I_WDATA = 16'h0000, O_RDATA, e;
  logic [12:0] I_EVENT = 13'h0000, en, r;
  logic        O_ALARM_PIN, O_AMP_ENABLE, O_THRESH_SENSE_SEL;
  logic [5:0]  O_CLAMP;
  logic [15:0] exp_q[$];
  int          error_cnt = 0, samples_checked = 0;
  wire  [15:0] obs = {6'h00, seen, O_ALARM_PIN, O_AMP_ENABLE, O_CLAMP, O_THRESH_SENSE_SEL};

  always #5 I_CLK = ~I_CLK;

  alarm_output_clamp_control DUT (.I_CLK, .I_SYS_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
    .I_EVENT, .O_RDATA, .O_ALARM_PIN, .O_AMP_ENABLE, .O_CLAMP, .O_THRESH_SENSE_SEL);
  alarm_host_model host (.I_CLK(I_CLK), .i_pin(O_ALARM_PIN), .i_active_high(pol),
    .o_alarm_seen(seen));

  always @(posedge I_CLK)
    rd_d <= I_RD;

  // read data only stands one cycle, so compare mid-cycle
  always @(negedge I_CLK)
    if (rd_d || look)
    begin
      e = exp_q.pop_front();
      `CMP(e, rd_d ? O_RDATA : obs)
    end

  task automatic w(input int n);
    repeat (n) @(posedge I_CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge I_CLK);
    I_ADDR  <= a;
    I_WDATA <= d;
    I_WR    <= 1'b1;
    @(posedge I_CLK);
    I_WR    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    exp_q.push_back(x);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_RD   <= 1'b1;
    @(posedge I_CLK);
    I_RD   <= 1'b0;
  endtask

  // a: alarm logically active; pin level derived from polarity, select mirrors polarity
  // one idle edge first, so a probe never shares a sample slot with read data
  task automatic pr(input logic a, input logic amp, input logic [5:0] cl);
    @(posedge I_CLK);
    exp_q.push_back({6'h00, a, a ~^ pol, amp, cl, pol});
    look <= 1'b1;
    @(posedge I_CLK);
    look <= 1'b0;
  endtask

  task automatic wrap_up;
    if (exp_q.size() != 0)
      error_cnt++;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'hEBEEF7E0));
    w(12);
    I_SYS_RST <= 1'b0;
    rd(alarm_clamp_pkg::ADDR_CLAMP_ROUTING, alarm_clamp_pkg::RST_CLAMP_ROUTING);
    rd(alarm_clamp_pkg::ADDR_OUTPUT_CONFIG, alarm_clamp_pkg::RST_OUTPUT_CONFIG);
    rd(8'h33, 16'h0000);
    pr(1'b0, 1'b0, 6'h00);
    wr(alarm_clamp_pkg::ADDR_CLAMP_ROUTING, 16'hFFC1);
    rd(alarm_clamp_pkg::ADDR_CLAMP_ROUTING, 16'h0041);
    // pass 0 latched, active low, internal inputs; pass 1 the opposite of each
    for (int m = 0; m < 2; m++)
    begin
      en = 13'h0001 << $urandom_range(12, 0);
      r  = 13'($urandom()) & ~en;
      wr(alarm_clamp_pkg::ADDR_OUTPUT_CONFIG, {m[0], m[0], m[0], en});
      pol <= m[0];
      wr(alarm_clamp_pkg::ADDR_AMP_COMMAND, 16'h0001);
      I_EVENT <= r;
      w(6);
      pr(1'b0, 1'b1, 6'h00);
      I_EVENT <= en;
      w(6);
      pr(1'b1, 1'b0, 6'h01);
      I_EVENT <= 13'h0000;
      w(6);
      pr(~m[0], 1'b0, 6'h01);
      rd(alarm_clamp_pkg::ADDR_ALARM_STATUS, m ? 16'h0000 : {3'h0, r | en});
      w(6);
      pr(1'b0, 1'b0, 6'h01);
      rd(alarm_clamp_pkg::ADDR_CLAMP_WAKE, 16'h0001);
      wr(alarm_clamp_pkg::ADDR_CLAMP_WAKE, 16'h003F);
      wr(alarm_clamp_pkg::ADDR_AMP_COMMAND, 16'h0001);
      w(6);
      pr(1'b0, 1'b1, 6'h00);
    end
    wr(8'h33, 16'hFFFF);
    rd(alarm_clamp_pkg::ADDR_CLAMP_ROUTING, 16'h0041);
    rd(alarm_clamp_pkg::ADDR_AMP_COMMAND, 16'h0001);
    rd(alarm_clamp_pkg::ADDR_CLAMP_WAKE, 16'h0000);
    wr(alarm_clamp_pkg::ADDR_AMP_COMMAND, 16'h0000);
    pr(1'b0, 1'b0, 6'h00);
    wrap_up();
  end

  initial
  begin
    w(2000);
    error_cnt++;
    wrap_up();
  end
endmodule
